// [logic/trc_pkg.sv]
// package for the translation buffer unit reliability register bank
package trc_pkg;
    // register byte offsets on the avalon word bus
    localparam logic [7:0] OFF_FEATURE    = 8'h00;
    localparam logic [7:0] OFF_CONTROL    = 8'h04;
    localparam logic [7:0] OFF_SECURE     = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h10;
    // field positions
    localparam int FI_LSB      = 6;
    localparam int ED_LSB      = 0;
    localparam int CTL_EN_BIT  = 3;
    localparam int NONSECURE_RELIABILITY_ACCESS_BIT_BIT  = 1;
    // fixed capability field values
    localparam logic [1:0] FI_VALUE = 2'h2;
    localparam logic [1:0] ED_VALUE = 2'h1;
    // reset values
    localparam logic RST_CTL_EN   = 1'h1;
    localparam logic RST_IRQ_MASK = 1'h1;

    // bus request bundle
    typedef struct packed {
        logic        read;
        logic        write;
        logic        nonsecure;
        logic [7:0]  address;
        logic [31:0] writedata;
    } trc_req_s;

    // all state of the bank except the input synchroniser flops
    typedef struct packed {
        logic        ctl_en;
        logic        nonsecure_reliability_access_bit;
        logic        strap_done;
        logic        fault_sticky;
        logic        irq_mask;
        logic        ack;
        logic [31:0] rdata;
    } trc_state_s;
endpackage

// [logic/trc_ras_regs.sv]
// reliability feature and error control registers of one translation buffer unit
`timescale 1ns/1ps
module trc_ras_regs
    import trc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic        avs_nonsecure_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        sec_override_in,
    input  wire logic        fault_in,
    output logic             ras_fault_irq_out,
    output logic             irq_out
);
    trc_state_s state;
    trc_state_s next_state;
    trc_req_s   req;
    logic       sec_override_s1;
    logic       sec_override_s2;
    logic       fault_s1;
    logic       fault_s2;
    logic       fault_event;
    logic       access;
    logic       ns_block;
    logic       wr_take;
    logic [31:0] rd_mux;

    // bundle the bus request
    assign req = '{read: avs_read_in, write: avs_write_in, nonsecure: avs_nonsecure_in,
                   address: avs_address_in, writedata: avs_writedata_in};

    // override tie synchroniser runs through reset so the tie is settled at release
    always_ff @(posedge clk_in) begin
        sec_override_s1 <= sec_override_in;
        sec_override_s2 <= sec_override_s1;
    end

    // two-flop synchroniser for the fault pin
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fault_s1        <= 1'h0;
            fault_s2        <= 1'h0;
        end else begin
            fault_s1        <= fault_in;
            fault_s2        <= fault_s1;
        end
    end

    // a fault is a level on the synchronised fault input
    assign fault_event = fault_s2;

    // one wait cycle: request is taken on the edge where ack is high
    assign access  = (req.read | req.write) & ~state.ack;
    assign wr_take = req.write & state.ack;
    // nonsecure accesses blocked while the access bit is clear
    assign ns_block = req.nonsecure & ~state.nonsecure_reliability_access_bit;

    // read data selection
    always_comb begin
        rd_mux = 32'h0;
        unique case (req.address)
            OFF_FEATURE: begin
                rd_mux[FI_LSB +: 2] = FI_VALUE;
                rd_mux[ED_LSB +: 2] = ED_VALUE;
            end
            OFF_CONTROL: begin
                rd_mux[CTL_EN_BIT] = state.ctl_en;
            end
            OFF_SECURE: begin
                rd_mux[NONSECURE_RELIABILITY_ACCESS_BIT_BIT] = req.nonsecure ? 1'h0 : state.nonsecure_reliability_access_bit;
            end
            OFF_IRQ_STATUS: begin
                rd_mux[0] = state.fault_sticky;
            end
            OFF_IRQ_MASK: begin
                rd_mux[0] = state.irq_mask;
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
        if (ns_block && req.address != OFF_SECURE) begin
            rd_mux = 32'h0;
        end
    end

    // next-state logic
    always_comb begin
        next_state     = state;
        next_state.ack = access;
        if (access) begin
            next_state.rdata = req.read ? rd_mux : 32'h0;
        end
        // override tie caught once after reset release
        if (!state.strap_done) begin
            next_state.nonsecure_reliability_access_bit     = sec_override_s2;
            next_state.strap_done = 1'h1;
        end
        if (wr_take) begin
            unique case (req.address)
                OFF_CONTROL: begin
                    if (!ns_block) begin
                        next_state.ctl_en = req.writedata[CTL_EN_BIT];
                    end
                end
                OFF_SECURE: begin
                    if (!req.nonsecure) begin
                        next_state.nonsecure_reliability_access_bit = req.writedata[NONSECURE_RELIABILITY_ACCESS_BIT_BIT];
                    end
                end
                OFF_IRQ_STATUS: begin
                    if (!ns_block && req.writedata[0]) begin
                        next_state.fault_sticky = 1'h0;
                    end
                end
                OFF_IRQ_MASK: begin
                    if (!ns_block) begin
                        next_state.irq_mask = req.writedata[0];
                    end
                end
                default: begin
                end
            endcase
        end
        // a fault seen while enabled is recorded; set wins over clear
        if (fault_event && state.ctl_en) begin
            next_state.fault_sticky = 1'h1;
        end
    end

    // state register; this module is one unit's private copy
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state.ctl_en       <= RST_CTL_EN;
            state.nonsecure_reliability_access_bit       <= 1'h0;
            state.strap_done   <= 1'h0;
            state.fault_sticky <= 1'h0;
            state.irq_mask     <= RST_IRQ_MASK;
            state.ack          <= 1'h0;
            state.rdata        <= 32'h0;
        end else begin
            state <= next_state;
        end
    end

    // bus answers and interrupt outputs
    assign avs_waitrequest_out = ~state.ack;
    assign avs_readdata_out    = state.rdata;
    assign ras_fault_irq_out   = fault_event & state.ctl_en;
    assign irq_out             = state.fault_sticky & state.irq_mask;
endmodule

// [test/trc_ras_asserts.sv]
// assertion checker for the reliability register bank
`timescale 1ns/1ps
module trc_ras_asserts (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [7:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic        avs_nonsecure_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        sec_override_in,
    input wire logic        fault_in,
    input wire logic        ras_fault_irq_out,
    input wire logic        irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic rok;
    logic wok;
    // completing secure read, completing secure write to error control
    assign rok = avs_read_in && !avs_waitrequest_out && !avs_nonsecure_in;
    assign wok = avs_write_in && !avs_waitrequest_out && !avs_nonsecure_in
                 && avs_address_in == 8'h04;
    chk_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("bus answer late");
    chk_wait_idle: assert property (!avs_read_in && !avs_write_in |-> avs_waitrequest_out)
        else $error("answer without request");
    chk_feature_read: assert property (rok && avs_address_in == 8'h00
        |-> avs_readdata_out == 32'h81) else $error("feature value wrong");
    chk_secure_hidden: assert property (avs_read_in && !avs_waitrequest_out
        && avs_nonsecure_in && avs_address_in == 8'h08 |-> avs_readdata_out == 32'h0)
        else $error("secure control visible");
    chk_irq_cause: assert property (ras_fault_irq_out |-> $past(fault_in, 2))
        else $error("fault irq without fault");
    chk_enable_off: assert property (wok && !avs_writedata_in[3]
        |=> !ras_fault_irq_out [*2]) else $error("fault irq while disabled");
    chk_enable_on: assert property (wok && avs_writedata_in[3]
        ##1 !avs_write_in ##1 (fault_in && !avs_write_in) [*2] |=> ras_fault_irq_out)
        else $error("fault irq missing");
    chk_sticky_drop: assert property ($fell(irq_out) |-> $past(avs_write_in))
        else $error("irq dropped without write");
endmodule
bind trc_ras_regs trc_ras_asserts chk_i (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_nonsecure_in(avs_nonsecure_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .sec_override_in(sec_override_in),
    .fault_in(fault_in), .ras_fault_irq_out(ras_fault_irq_out), .irq_out(irq_out));

// [test/tbu_ras_error_control_test.sv]
// self-checking bench for the reliability register bank
`timescale 1ns/1ps
module tbu_ras_error_control_test;
    import trc_pkg::*;
    logic        clk = 1'h0, rst = 1'h1, rd = 1'h0, wr = 1'h0, ns = 1'h0;
    logic        ovr = 1'h0, flt = 1'h0, wreq, rirq, irq;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wd = 32'h0, rdata, v, seed = 32'h71eb64b1;
    logic [31:0] exp_q[$];
    int          miscompares = 0, checked = 0, cyc = 0;
    trc_ras_regs DUT (.clk_in(clk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd), .avs_nonsecure_in(ns),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .sec_override_in(ovr),
        .fault_in(flt), .ras_fault_irq_out(rirq), .irq_out(irq));
    // clock and timeout
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (++cyc == 3000) begin
        miscompares++;
        end_sim();
    end
    task automatic chk(input string n, input logic [31:0] e, s);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one bus transfer, a read notes its expected data
    task automatic bus(input logic w, n, input logic [7:0] a, input logic [31:0] d, e);
        if (!w) exp_q.push_back(e);
        rd <= !w; wr <= w; ns <= n; addr <= a; wd <= d;
        do @(posedge clk); while (wreq);
        rd <= 1'h0; wr <= 1'h0;
        @(posedge clk); // idle edge so the next call never reassigns in this step
    endtask
    // read data watcher
    always @(posedge clk) if (rd && wreq === 1'h0) chk("readdata", exp_q.pop_front(), rdata);
    task automatic fault(input logic [1:0] e);
        flt <= 1'h1;
        repeat (4) @(posedge clk);
        chk("irqs", e, {rirq, irq});
        flt <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic rst_seq();
        rst <= 1'h1;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        rst_seq();
        bus(0, 0, 8'h00, 0, 32'h81);
        bus(0, 0, 8'h04, 0, 32'h8);
        bus(0, 1, 8'h04, 0, 32'h0);
        bus(1, 1, 8'h04, 32'h0, 0);
        bus(0, 1, 8'h00, 0, 32'h0);
        bus(0, 0, 8'h04, 0, 32'h8);
        bus(1, 0, 8'h08, 32'h2, 0);
        bus(0, 1, 8'h04, 0, 32'h8);
        bus(0, 1, 8'h08, 0, 32'h0);
        bus(0, 0, 8'h14, 0, 32'h0);
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            bus(1, i[0], 8'h04, v, 0);
            bus(0, 0, 8'h04, 0, v & 32'h8);
        end
        bus(1, 0, 8'h04, 32'h8, 0);
        fault(2'h3);
        bus(1, 0, 8'h0c, 32'h1, 0);
        chk("irq", 1'h0, irq);
        bus(1, 0, 8'h10, 32'h0, 0);
        fault(2'h2);
        bus(1, 0, 8'h10, 32'h1, 0);
        chk("irq", 1'h1, irq);
        bus(1, 0, 8'h0c, 32'h1, 0);
        bus(1, 0, 8'h04, 32'h0, 0);
        fault(2'h0);
        ovr <= 1'h1;
        rst_seq();
        bus(0, 1, 8'h04, 0, 32'h8);
        end_sim();
    end
endmodule
